// ==== common/ebt_pkg.sv ====
// Package for the eight-bit timer with event counting and capture
package ebt_pkg;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned ADDR_W        = 2;
   localparam int unsigned DATA_W        = 8;
   localparam int unsigned DIV_W         = 16;

   // Register index and byte address coincide on this plain port
   localparam logic [ADDR_W-1:0] OFF_CTRL  = 2'h0;
   localparam logic [ADDR_W-1:0] OFF_REG_A = 2'h1;
   localparam logic [ADDR_W-1:0] OFF_REG_B = 2'h2;
   localparam logic [ADDR_W-1:0] OFF_PRESC = 2'h3;

   // Control and prescaler register fields
   localparam int unsigned CTRL_CAP_BIT  = 0;
   localparam int unsigned CTRL_CKS_LSB  = 1;
   localparam int unsigned CTRL_CKS_MSB  = 3;
   localparam int unsigned CTRL_RUN_BIT  = 4;
   localparam int unsigned CTRL_SNAP_BIT = 6;
   localparam int unsigned PRESC_DIV_BIT = 0;

   localparam logic [7:0] CTRL_RST   = 8'h00;
   localparam logic [7:0] REG_A_RST  = 8'h00;
   localparam logic [7:0] REG_B_RST  = 8'hFF;
   localparam logic [7:0] CNT_RST    = 8'h00;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CTRL_RMASK = 8'h5F;

   // Source clock select: 000 is the slowest internal period, 111 the pin
   localparam logic [2:0] CKS_EXT      = 3'h7;
   localparam logic [3:0] DIV_EXP_BASE = 4'hD;

   typedef enum logic [1:0] {
      EBT_MODE_TIMER,
      EBT_MODE_EVENT,
      EBT_MODE_CAPTURE
   } ebt_mode_t;
endpackage : ebt_pkg

// ==== common/ebt_edge_if.sv ====
// Interface carrying the synchronised pin level and its edges
interface ebt_edge_if;
   logic level;
   logic rise;
   logic fall;

   modport drv (output level, output rise, output fall);
   modport use_ (input level, input rise, input fall);
endinterface : ebt_edge_if

// ==== rtl/ebt_edge_sync.sv ====
// Synchroniser and edge detector for the count input pin
module ebt_edge_sync (
   input  wire logic   core_clk_in,
   input  wire logic   sys_rst_in,
   input  wire logic   clk_en_in,
   input  wire logic   pin_in,
   ebt_edge_if.drv     edge_bus
);
   logic sync_first;
   logic sync_second;
   logic prev;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         sync_first  <= 1'b0;
         sync_second <= 1'b0;
         prev        <= 1'b0;
      end else if (clk_en_in) begin
         sync_first  <= pin_in;
         sync_second <= sync_first;
         prev        <= sync_second;
      end
   end

   assign edge_bus.level = sync_second;
   assign edge_bus.rise  = clk_en_in & sync_second & ~prev;
   assign edge_bus.fall  = clk_en_in & ~sync_second & prev;
endmodule : ebt_edge_sync

// ==== rtl/ebt_prescaler.sv ====
// Divider giving the internal source clock tick, cleared while the run bit is low
module ebt_prescaler (
   input  wire logic       core_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       clk_en_in,
   input  wire logic       run_in,
   input  wire logic [2:0] cks_in,
   input  wire logic       div2_in,
   output logic            tick_out
);
   logic [ebt_pkg::DIV_W-1:0] div;
   logic [ebt_pkg::DIV_W-1:0] mask;
   logic [3:0]                shift;

   // Held in reset while stopped so the first period after start is whole
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         div <= '0;
      end else if (clk_en_in) begin
         if (!run_in) begin
            div <= '0;
         end else begin
            div <= div + 16'h1;
         end
      end
   end

   always_comb begin
      shift = ebt_pkg::DIV_EXP_BASE - {1'b0, cks_in} + {3'h0, div2_in};
      mask  = (16'h1 << shift) - 16'h1;
   end

   assign tick_out = clk_en_in & run_in & (cks_in != ebt_pkg::CKS_EXT) & ((div & mask) == mask);
endmodule : ebt_prescaler

// ==== rtl/ebt_timer.sv ====
// Eight-bit timer/counter with timer, event counter and capture modes
//
// Local design decisions: the address map and the address-and-strobe port.
module ebt_timer (
   input  wire logic       core_clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       clk_en_in,
   input  wire logic [1:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   input  wire logic       count_input_pin_in,
   input  wire logic       stop_mode_in,
   output logic            counter_irq_out
);
   logic [7:0]        counter_control_reg;
   logic [7:0]        compare_capture_reg_a;
   logic [7:0]        capture_reg_b;
   logic              prescaler_divide_select;
   logic [7:0]        cnt;
   logic [7:0]        next_cnt;
   logic              suspended;
   logic              tick;
   logic              run_bit;
   logic              auto_snapshot_enable;
   logic [2:0]        source_clock_select;
   logic              read_a;
   logic              incr;
   logic              match_clr;
   logic              cap_rise;
   logic              cap_fall;
   logic              ovf;
   ebt_pkg::ebt_mode_t mode;

   ebt_edge_if pin_edge ();

   ebt_edge_sync u_edge (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .clk_en_in   (clk_en_in),
      .pin_in      (count_input_pin_in),
      .edge_bus    (pin_edge.drv)
   );

   assign run_bit              = counter_control_reg[ebt_pkg::CTRL_RUN_BIT];
   assign auto_snapshot_enable = counter_control_reg[ebt_pkg::CTRL_SNAP_BIT];
   assign source_clock_select  = counter_control_reg[ebt_pkg::CTRL_CKS_MSB:ebt_pkg::CTRL_CKS_LSB];

   ebt_prescaler u_presc (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .clk_en_in   (clk_en_in),
      .run_in      (run_bit),
      .cks_in      (source_clock_select),
      .div2_in     (prescaler_divide_select),
      .tick_out    (tick)
   );

   // Capture bit overrides; clock select 111 routes the pin as count source
   always_comb begin
      if (counter_control_reg[ebt_pkg::CTRL_CAP_BIT]) begin
         mode = ebt_pkg::EBT_MODE_CAPTURE;
      end else if (source_clock_select == ebt_pkg::CKS_EXT) begin
         mode = ebt_pkg::EBT_MODE_EVENT;
      end else begin
         mode = ebt_pkg::EBT_MODE_TIMER;
      end
   end

   assign read_a = clk_en_in & reg_rd_in & (reg_addr_in == ebt_pkg::OFF_REG_A);

   // Counting decisions; a rising pin edge outranks a source tick in capture mode
   always_comb begin
      incr      = 1'b0;
      match_clr = 1'b0;
      cap_rise  = 1'b0;
      cap_fall  = 1'b0;
      ovf       = 1'b0;
      next_cnt  = cnt;
      if (run_bit && clk_en_in) begin
         case (mode)
            ebt_pkg::EBT_MODE_TIMER: begin
               if (tick) begin
                  if (cnt == compare_capture_reg_a) begin
                     match_clr = 1'b1;
                  end else begin
                     incr = 1'b1;
                  end
               end
            end
            ebt_pkg::EBT_MODE_EVENT: begin
               if (pin_edge.rise) begin
                  incr = 1'b1;
               end else if (pin_edge.fall && cnt == compare_capture_reg_a) begin
                  match_clr = 1'b1;
               end
            end
            default: begin
               if (!suspended && pin_edge.rise) begin
                  cap_rise = 1'b1;
               end else if (!suspended && pin_edge.fall) begin
                  cap_fall = 1'b1;
               end
               if (!cap_rise && tick) begin
                  if (!suspended && cnt == ebt_pkg::CNT_MAX) begin
                     ovf = 1'b1;
                  end else begin
                     incr = 1'b1;
                  end
               end
            end
         endcase
         if (match_clr || cap_rise || ovf) begin
            next_cnt = ebt_pkg::CNT_RST;
         end else if (incr) begin
            next_cnt = cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cnt <= ebt_pkg::CNT_RST;
      end else if (clk_en_in) begin
         if (!run_bit) begin
            cnt <= ebt_pkg::CNT_RST;
         end else begin
            cnt <= next_cnt;
         end
      end
   end

   // Stop entry beats a software write of the run bit in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         counter_control_reg <= ebt_pkg::CTRL_RST;
      end else if (clk_en_in) begin
         if (reg_wr_in && reg_addr_in == ebt_pkg::OFF_CTRL) begin
            counter_control_reg <= reg_wdata_in;
         end
         if (stop_mode_in) begin
            counter_control_reg[ebt_pkg::CTRL_RUN_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         prescaler_divide_select <= 1'b0;
      end else if (clk_en_in && reg_wr_in && reg_addr_in == ebt_pkg::OFF_PRESC) begin
         prescaler_divide_select <= reg_wdata_in[ebt_pkg::PRESC_DIV_BIT];
      end
   end

   // Hardware captures win over a software write in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         compare_capture_reg_a <= ebt_pkg::REG_A_RST;
      end else if (clk_en_in) begin
         if (ovf) begin
            compare_capture_reg_a <= ebt_pkg::CNT_MAX;
         end else if (cap_rise) begin
            compare_capture_reg_a <= cnt;
         end else if (reg_wr_in && reg_addr_in == ebt_pkg::OFF_REG_A) begin
            compare_capture_reg_a <= reg_wdata_in;
         end
      end
   end

   // Snapshot follows increments only, so the post-match zero never lands in B
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         capture_reg_b <= ebt_pkg::REG_B_RST;
      end else if (clk_en_in) begin
         if (cap_fall) begin
            capture_reg_b <= cnt;
         end else if (auto_snapshot_enable && mode != ebt_pkg::EBT_MODE_CAPTURE && incr) begin
            capture_reg_b <= next_cnt;
         end
      end
   end

   // A new overflow wins over the re-arming read in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         suspended <= 1'b0;
      end else if (clk_en_in) begin
         if (ovf) begin
            suspended <= 1'b1;
         end else if (read_a || !run_bit) begin
            suspended <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         counter_irq_out <= 1'b0;
      end else if (clk_en_in) begin
         counter_irq_out <= match_clr | cap_rise | ovf;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (clk_en_in) begin
         if (!reg_rd_in) begin
            reg_rdata_out <= 8'h00;
         end else if (reg_addr_in == ebt_pkg::OFF_CTRL) begin
            reg_rdata_out <= counter_control_reg & ebt_pkg::CTRL_RMASK;
         end else if (reg_addr_in == ebt_pkg::OFF_REG_A) begin
            reg_rdata_out <= compare_capture_reg_a;
         end else if (reg_addr_in == ebt_pkg::OFF_REG_B) begin
            reg_rdata_out <= capture_reg_b;
         end else begin
            reg_rdata_out <= {7'h00, prescaler_divide_select};
         end
      end
   end

   irq_pulse_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      counter_irq_out && clk_en_in |=> !counter_irq_out)
      else $error("interrupt held longer than one cycle");

   timer_match_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_bit && !stop_mode_in && mode == ebt_pkg::EBT_MODE_TIMER && tick
      && cnt == compare_capture_reg_a |=> cnt == 8'h00 && counter_irq_out)
      else $error("timer match did not clear and interrupt");

   event_rise_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_bit && !stop_mode_in && mode == ebt_pkg::EBT_MODE_EVENT && pin_edge.rise
      |=> cnt == $past(cnt) + 8'h01 && !counter_irq_out)
      else $error("event rising edge not counted");

   event_fall_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_bit && mode == ebt_pkg::EBT_MODE_EVENT && pin_edge.fall
      |=> counter_irq_out == ($past(cnt) == $past(compare_capture_reg_a)))
      else $error("event match not judged on falling edge");

   cap_fall_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_bit && mode == ebt_pkg::EBT_MODE_CAPTURE && !suspended && pin_edge.fall
      |=> capture_reg_b == $past(cnt))
      else $error("falling edge did not capture into B");

   cap_rise_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_bit && !stop_mode_in && mode == ebt_pkg::EBT_MODE_CAPTURE && !suspended
      && pin_edge.rise |=> compare_capture_reg_a == $past(cnt) && cnt == 8'h00 && counter_irq_out
      && $stable(capture_reg_b))
      else $error("rising edge capture into A wrong");

   overflow_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_bit && !stop_mode_in && mode == ebt_pkg::EBT_MODE_CAPTURE && !suspended
      && tick && !pin_edge.rise && cnt == 8'hFF
      |=> compare_capture_reg_a == 8'hFF && cnt == 8'h00 && counter_irq_out && suspended)
      else $error("capture overflow handling wrong");

   suspend_hold_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && suspended && run_bit && !read_a |=> suspended && !counter_irq_out)
      else $error("capture resumed without a read of A");

   stop_clear_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && stop_mode_in |=> !run_bit ##1 cnt == 8'h00)
      else $error("stop entry did not halt the counter");

   snap_capture_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && mode == ebt_pkg::EBT_MODE_CAPTURE && !pin_edge.fall |=> $stable(capture_reg_b))
      else $error("B changed in capture mode without falling edge");

   snap_zero_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && match_clr |=> $stable(capture_reg_b))
      else $error("post-match zero copied into B");

   snap_copy_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_bit && auto_snapshot_enable && mode == ebt_pkg::EBT_MODE_TIMER && tick
      && cnt != compare_capture_reg_a |=> capture_reg_b == $past(cnt) + 8'h01)
      else $error("running count not copied into B");

   resume_read_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && suspended && read_a |=> !suspended)
      else $error("read of A did not resume capture");

   ctrl_read_a: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      clk_en_in && reg_rd_in && reg_addr_in == ebt_pkg::OFF_CTRL
      |=> reg_rdata_out[7] == 1'b0 && reg_rdata_out[5] == 1'b0)
      else $error("undefined control bits read back nonzero");
endmodule : ebt_timer

// ==== bench/ebt_pulse_src.sv ====
// Pulse source model standing on the count input pin
module ebt_pulse_src (
   input  wire logic core_clk_in,
   output logic      pin_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pin_out = 1'b0;

   // Level changes just after an edge; phases shorter than the sync chain would be lost
   task automatic drive(input logic lvl, input int hold);
      @(posedge core_clk_in);
      pin_out <= lvl;
      repeat ((hold < 4) ? 4 : hold) @(posedge core_clk_in);
   endtask : drive
endmodule : ebt_pulse_src

// ==== bench/ebt_timer_bench.sv ====
// Self-checking bench for the eight-bit timer
`define EBT_CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
   $display("CHECK FAILED at %0t: %s", $time, msg); end end

module ebt_timer_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic       core_clk_in;
   logic       sys_rst_in;
   logic [1:0] reg_addr_in;
   logic [7:0] reg_wdata_in;
   logic       reg_wr_in;
   logic       reg_rd_in;
   logic [7:0] reg_rdata_out;
   logic       pin;
   logic       stop_mode_in;
   logic       counter_irq_out;
   logic       rd_pend;
   logic       irq_d;
   logic [7:0] rd_q[$];
   logic [7:0] a_val;
   logic [7:0] c_val;
   logic       clk_en;
   int         num_errors;
   int         n_compared;
   int         irq_count;
   int         cyc;
   int         n;

   ebt_timer uut (
      .core_clk_in        (core_clk_in),
      .sys_rst_in         (sys_rst_in),
      .clk_en_in          (clk_en),
      .reg_addr_in        (reg_addr_in),
      .reg_wdata_in       (reg_wdata_in),
      .reg_wr_in          (reg_wr_in),
      .reg_rd_in          (reg_rd_in),
      .reg_rdata_out      (reg_rdata_out),
      .count_input_pin_in (pin),
      .stop_mode_in       (stop_mode_in),
      .counter_irq_out    (counter_irq_out)
   );

   ebt_pulse_src src (
      .core_clk_in (core_clk_in),
      .pin_out     (pin)
   );

   initial begin
      core_clk_in = 1'b0;
      forever #(ebt_pkg::CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;
   end

   function automatic logic [7:0] ctrl_val(input logic [2:0] cks, input logic cap, input logic run);
      ctrl_val = 8'h00;
      ctrl_val[ebt_pkg::CTRL_CKS_MSB:ebt_pkg::CTRL_CKS_LSB] = cks;
      ctrl_val[ebt_pkg::CTRL_CAP_BIT] = cap;
      ctrl_val[ebt_pkg::CTRL_RUN_BIT] = run;
      ctrl_val[ebt_pkg::CTRL_SNAP_BIT] = ~cap;
   endfunction : ctrl_val

   task automatic wr(input logic [1:0] addr, input logic [7:0] data);
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= addr;
      reg_wdata_in <= data;
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b0;
   endtask : wr

   // Each read strobes for one cycle and leaves one idle cycle before the next; the monitor pairs each with its note
   task automatic rd(input logic [1:0] addr, input logic [7:0] exp);
      rd_q.push_back(exp);
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= addr;
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b0;
   endtask : rd

   // Mode is settled with the run bit low, then the counter is started
   task automatic start(input logic [7:0] ctrl);
      wr(ebt_pkg::OFF_CTRL, ctrl);
      wr(ebt_pkg::OFF_CTRL, ctrl | 8'h10);
   endtask : start

   task automatic wait_irq(input int bound, output int cnt);
      int c0;
      c0  = irq_count;
      cnt = 0;
      while (irq_count == c0 && cnt < bound) begin
         @(posedge core_clk_in);
         cnt++;
      end
      if (irq_count == c0) cnt = -1;
   endtask : wait_irq

   task automatic timer_run(input logic [2:0] cks, input logic div, input int exp);
      int got;
      wr(ebt_pkg::OFF_PRESC, {7'h00, div});
      wr(ebt_pkg::OFF_REG_A, 8'h02);
      start(ctrl_val(cks, 1'b0, 1'b0));
      wait_irq(exp + 20, got);
      `EBT_CHK(got >= exp - 4 && got <= exp + 6, 1'b1, "timer period")
      rd(ebt_pkg::OFF_REG_B, 8'h02);
      wr(ebt_pkg::OFF_CTRL, ctrl_val(cks, 1'b0, 1'b0));
   endtask : timer_run

   task automatic tally_and_finish();
      if (num_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge core_clk_in) begin
      rd_pend <= reg_rd_in;
      irq_d   <= counter_irq_out;
      if (counter_irq_out === 1'b1) irq_count <= irq_count + 1;
      if (irq_d === 1'b1) `EBT_CHK(counter_irq_out, 1'b0, "irq longer than one cycle")
      if (rd_pend === 1'b1) `EBT_CHK(reg_rdata_out, rd_q.pop_front(), "read data")
      cyc <= cyc + 1;
      // A clean run needs about 85000 clocks, mostly the slow timer codes and the overflow
      if (cyc == 95000) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, "timeout");
         tally_and_finish();
      end
   end

   initial begin
      sys_rst_in = 1'b1;
      reg_addr_in = 2'h0;
      reg_wdata_in = 8'h00;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      stop_mode_in = 1'b0;
      clk_en = 1'b1;
      num_errors = 0;
      n_compared = 0;
      void'($urandom(10));
      repeat (3) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      rd(ebt_pkg::OFF_CTRL, ebt_pkg::CTRL_RST);
      rd(ebt_pkg::OFF_REG_A, ebt_pkg::REG_A_RST);
      rd(ebt_pkg::OFF_REG_B, ebt_pkg::REG_B_RST);
      rd(ebt_pkg::OFF_PRESC, 8'h00);
      // Capture: first edge rising leaves B at its reset value, tick every 128 clocks
      start(ctrl_val(3'h6, 1'b1, 1'b0));
      src.drive(1'b1, 0);
      wait_irq(400, n);
      `EBT_CHK(n > 0, 1'b1, "capture irq on first rise")
      rd(ebt_pkg::OFF_REG_B, 8'hFF);
      rd(ebt_pkg::OFF_REG_A, 8'h00);
      // Ticks land 128 clocks apart: the fall sees a count of 3, the next rise 5
      src.drive(1'b1, 400);
      src.drive(1'b0, 256);
      src.drive(1'b1, 0);
      wait_irq(40, n);
      `EBT_CHK(n > 0, 1'b1, "capture irq on rise")
      rd(ebt_pkg::OFF_REG_B, 8'h03);
      rd(ebt_pkg::OFF_REG_A, 8'h05);
      wait_irq(33500, n);
      `EBT_CHK(n > 32000, 1'b1, "overflow irq")
      src.drive(1'b0, 300);
      src.drive(1'b1, 300);
      `EBT_CHK(irq_count, 3, "edges seen while suspended")
      rd(ebt_pkg::OFF_REG_B, 8'h03);
      rd(ebt_pkg::OFF_REG_A, 8'hFF);
      src.drive(1'b0, 300);
      src.drive(1'b1, 0);
      wait_irq(40, n);
      `EBT_CHK(n > 0, 1'b1, "capture resumed after read")
      wr(ebt_pkg::OFF_CTRL, ctrl_val(3'h6, 1'b1, 1'b0));
      // Every internal source clock code, then the doubled period
      for (int c = 0; c < 7; c++) timer_run(3'(c), 1'b0, 3 << (13 - c));
      timer_run(3'h6, 1'b1, 768);
      wr(ebt_pkg::OFF_PRESC, 8'h00);
      // Event counting with a random compare value
      a_val = 8'h02 + 8'($urandom % 4);
      src.drive(1'b0, 6);
      wr(ebt_pkg::OFF_REG_A, a_val);
      start(ctrl_val(ebt_pkg::CKS_EXT, 1'b0, 1'b0));
      n = irq_count;
      for (int p = 1; p < a_val; p++) begin
         src.drive(1'b1, 6);
         src.drive(1'b0, 6);
      end
      rd(ebt_pkg::OFF_REG_B, a_val - 8'h01);
      src.drive(1'b1, 8);
      `EBT_CHK(irq_count, n, "irq before falling edge")
      src.drive(1'b0, 8);
      `EBT_CHK(irq_count, n + 1, "irq at falling edge")
      rd(ebt_pkg::OFF_REG_B, a_val);
      src.drive(1'b1, 6);
      src.drive(1'b0, 6);
      rd(ebt_pkg::OFF_REG_B, 8'h01);
      // Stop mode drops the run bit; bits 5 and 7 never read back
      @(posedge core_clk_in);
      stop_mode_in <= 1'b1;
      @(posedge core_clk_in);
      stop_mode_in <= 1'b0;
      rd(ebt_pkg::OFF_CTRL, ctrl_val(ebt_pkg::CKS_EXT, 1'b0, 1'b0));
      c_val = 8'hA0 | (8'($urandom % 16) & 8'hEF);
      wr(ebt_pkg::OFF_CTRL, c_val);
      rd(ebt_pkg::OFF_CTRL, c_val & 8'h5F);
      // With the clock enable low a write to A is lost and A keeps its value
      clk_en <= 1'b0;
      wr(ebt_pkg::OFF_REG_A, ~a_val);
      clk_en <= 1'b1;
      rd(ebt_pkg::OFF_REG_A, a_val);
      tally_and_finish();
   end
endmodule : ebt_timer_bench
